// File: pkg/asrad_defines.svh
// Register map, field positions, reset values and timing counts of the serial receiver
//
// Overview of operation
// RL1 - Sample line at sixteen times bit rate
// RL2 - Receive only after receive_enable is set
// RL3 - Stop bit moves word, sets ready flag
// RL4 - Interrupt forwarded only when enable bit set
// RL5 - Ready flag read-only, clears when FIFO empty
// RL6 - Two-entry FIFO, reads return words in order
// RL7 - Full FIFO at stop sets overrun, drops word
// RL8 - Overrun clears only by toggling receive_enable
// RL9 - Overrun blocks all transfers into FIFO
// RL10 - Low stop bit sets framing error
// RL11 - Error and ninth bit queued per entry
// RL12 - Software reads status before data port
// RL13 - nine_bit_receive adds ninth captured bit
// RL14 - Software follows address-detect setup order
// RL15 - Address filter loads only address words
// RL16 - Software clears errors via receive_enable
// RL17 - Address word means ninth bit is one
// RL18 - Frame: start, 8/9 data LSB first, stop
// RL19 - sync_mode_select clear selects asynchronous mode
// RL20 - Baud clock x16 or x64 by high_speed_baud
`ifndef ASRAD_DEFINES_SVH
`define ASRAD_DEFINES_SVH

// Register indices; byte address is four times the index
`define ASRAD_IDX_FLAG      10'h00c
`define ASRAD_IDX_RXCTL     10'h018
`define ASRAD_IDX_FIFO      10'h01a
`define ASRAD_IDX_IE        10'h08c
`define ASRAD_IDX_TXCTL     10'h098
`define ASRAD_IDX_BAUD      10'h099

// Field positions
`define ASRAD_B_PORT_EN     7
`define ASRAD_B_NINE_EN     6
`define ASRAD_B_RX_EN       4
`define ASRAD_B_ADDR_EN     3
`define ASRAD_B_FRAME_ERR   2
`define ASRAD_B_OVERRUN     1
`define ASRAD_B_NINTH       0
`define ASRAD_B_FLAG        5
`define ASRAD_B_IE          5
`define ASRAD_B_SYNC        4
`define ASRAD_B_HIGH_SPEED  2
`define ASRAD_B_TRMT        1

// Writable bits and reset values
`define ASRAD_RXCTL_WMASK   8'hf8
`define ASRAD_TXCTL_WMASK   8'hf5
`define ASRAD_RST_REG       8'h00
`define ASRAD_RST_TXCTL     8'h02

// Timing counts: sample ticks, prescaler steps and last data bit indices
`define ASRAD_MID_TICK      4'h7
`define ASRAD_LAST_TICK     4'hf
`define ASRAD_PRE_LAST      2'h3
`define ASRAD_BITS8_LAST    4'h7
`define ASRAD_BITS9_LAST    4'h8

`endif

// File: pkg/asrad_pkg.sv
// Types shared by the serial receiver
package asrad_pkg;

    typedef struct packed {
        logic       framing_error;
        logic       ninth;
        logic [7:0] data;
    } asrad_entry_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [9:0] idx;
    } asrad_aphase_type;

    typedef enum logic [1:0] {
        ASRAD_IDLE  = 2'b00,
        ASRAD_START = 2'b01,
        ASRAD_DATA  = 2'b10,
        ASRAD_STOP  = 2'b11
    } asrad_state_type;

endpackage : asrad_pkg

// File: design/asrad_receiver.sv
// Asynchronous serial receiver with two-deep FIFO, address detect and AHB-Lite registers
`timescale 1ns/1ps
`include "asrad_defines.svh"

module asrad_receiver (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rx_pin,
    output logic             rx_irq
);
    import asrad_pkg::*;

    // ------------------------------------------------------------
    // Line synchroniser
    // ------------------------------------------------------------
    logic [2:0] rx_sync;
    logic       rx_line;
    logic       next_rx_line;

    // A change counts only once the two later stages agree
    always_comb begin
        next_rx_line = (rx_sync[1] == rx_sync[2]) ? rx_sync[2] : rx_line;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_sync <= 3'h7;
            rx_line <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], rx_pin};
            rx_line <= next_rx_line;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]       rx_ctl, tx_ctl, irq_en, baud_div;
    logic             overrun_error;
    asrad_entry_type  fifo_mem [2];
    logic             head;
    logic [1:0]       count;
    asrad_state_type  state;
    logic [3:0]       tick_cnt, bit_cnt;
    logic [8:0]       shift;
    logic             nine;
    logic [7:0]       baud_cnt;
    logic [1:0]       pre_cnt;
    asrad_aphase_type aphase;

    logic [7:0]       next_rx_ctl, next_tx_ctl, next_irq_en, next_baud_div;
    logic             next_overrun_error;
    asrad_entry_type  next_mem [2];
    logic             next_head;
    logic [1:0]       next_count;
    asrad_state_type  next_state;
    logic [3:0]       next_tick_cnt, next_bit_cnt;
    logic [8:0]       next_shift;
    logic             next_nine;
    logic [7:0]       next_baud_cnt;
    logic [1:0]       next_pre_cnt;
    asrad_aphase_type next_aphase;
    logic [31:0]      next_hrdata;
    logic             next_irq;

    logic             rx_on, brg_tick, sample_tick, finish, full, push, pop, flag;
    logic             take, tail;
    asrad_entry_type  push_entry, head_entry;
    logic [9:0]       ap_idx;
    logic [7:0]       wbyte, rd_byte;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        // Receive path runs only when enabled in asynchronous mode
        rx_on = rx_ctl[`ASRAD_B_PORT_EN] & rx_ctl[`ASRAD_B_RX_EN]
              & ~tx_ctl[`ASRAD_B_SYNC];                                      // RL2 RL19
        brg_tick    = (baud_cnt == 8'h00);
        // x64 generator needs a further divide by four to reach x16
        sample_tick = brg_tick & (tx_ctl[`ASRAD_B_HIGH_SPEED]
                    | (pre_cnt == `ASRAD_PRE_LAST));                         // RL1 RL20
        next_baud_cnt = (!rx_on || brg_tick) ? baud_div : baud_cnt - 8'h01;
        next_pre_cnt  = !rx_on ? 2'h0 : (brg_tick ? pre_cnt + 2'h1 : pre_cnt);

        next_state    = state;
        next_tick_cnt = tick_cnt;
        next_bit_cnt  = bit_cnt;
        next_shift    = shift;
        next_nine     = nine;
        finish        = 1'b0;
        if (!rx_on) begin
            next_state = ASRAD_IDLE;                                         // RL2
        end else begin
            case (state)
                ASRAD_IDLE: begin
                    if (!rx_line) begin
                        next_state    = ASRAD_START;
                        next_tick_cnt = 4'h0;
                        next_nine     = rx_ctl[`ASRAD_B_NINE_EN];            // RL13
                    end
                end
                ASRAD_START: begin
                    if (sample_tick) begin
                        next_tick_cnt = tick_cnt + 4'h1;
                        if (tick_cnt == `ASRAD_MID_TICK) begin
                            // A glitch shorter than half a bit is rejected
                            next_state    = rx_line ? ASRAD_IDLE : ASRAD_DATA;   // RL18
                            next_tick_cnt = 4'h0;
                            next_bit_cnt  = 4'h0;
                        end
                    end
                end
                ASRAD_DATA: begin
                    if (sample_tick) begin
                        next_tick_cnt = tick_cnt + 4'h1;
                        if (tick_cnt == `ASRAD_LAST_TICK) begin
                            next_shift   = {rx_line, shift[8:1]};            // RL18
                            next_bit_cnt = bit_cnt + 4'h1;
                            if (bit_cnt == (nine ? `ASRAD_BITS9_LAST
                                                 : `ASRAD_BITS8_LAST)) begin
                                next_state = ASRAD_STOP;
                            end
                        end
                    end
                end
                ASRAD_STOP: begin
                    if (sample_tick) begin
                        next_tick_cnt = tick_cnt + 4'h1;
                        if (tick_cnt == `ASRAD_LAST_TICK) begin
                            finish     = 1'b1;                               // RL3
                            next_state = ASRAD_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = ASRAD_IDLE;
                end
            endcase
        end

        push_entry.framing_error  = ~rx_line;                                         // RL10
        push_entry.ninth = nine & shift[8];                                  // RL13
        push_entry.data  = nine ? shift[7:0] : shift[8:1];
        full = (count == 2'h2);
        // Filtered words and words under overrun never reach the FIFO
        push = finish & ~full & ~overrun_error
             & ~(rx_ctl[`ASRAD_B_ADDR_EN] & nine & ~shift[8]);               // RL9 RL15 RL17
        next_overrun_error = ~rx_ctl[`ASRAD_B_RX_EN] ? 1'b0
                           : ((finish & full) ? 1'b1 : overrun_error);       // RL7 RL8

        head_entry = fifo_mem[head];
        flag       = (count != 2'h0);                                        // RL5

        // Bus address phase
        take    = hsel & hready & htrans[1];
        ap_idx  = haddr[11:2];
        rd_byte = 8'h00;
        case (ap_idx)
            `ASRAD_IDX_FLAG:  rd_byte[`ASRAD_B_FLAG] = flag;
            `ASRAD_IDX_RXCTL: rd_byte = {rx_ctl[7:3], head_entry.framing_error, overrun_error,
                                         head_entry.ninth};                  // RL11
            `ASRAD_IDX_FIFO:  rd_byte = head_entry.data;
            `ASRAD_IDX_IE:    rd_byte = irq_en;
            `ASRAD_IDX_TXCTL: rd_byte = tx_ctl | `ASRAD_RST_TXCTL;
            `ASRAD_IDX_BAUD:  rd_byte = baud_div;
            default:          rd_byte = 8'h00;
        endcase
        next_hrdata = take && !hwrite ? {24'h000000, rd_byte} : hrdata;
        pop = take & ~hwrite & (ap_idx == `ASRAD_IDX_FIFO) & flag;           // RL6
        next_aphase.valid = take;
        next_aphase.write = hwrite;
        next_aphase.idx   = ap_idx;

        // FIFO update; a push and a pop together keep the count
        tail        = head ^ count[0];
        next_mem[0] = fifo_mem[0];
        next_mem[1] = fifo_mem[1];
        if (push) begin
            next_mem[tail] = push_entry;                                     // RL11
        end
        next_head  = pop ? ~head : head;                                     // RL6
        next_count = count + {1'b0, push} - {1'b0, pop};

        // Bus data phase writes
        wbyte          = hwdata[7:0];
        next_rx_ctl    = rx_ctl;
        next_tx_ctl    = tx_ctl;
        next_irq_en    = irq_en;
        next_baud_div  = baud_div;
        if (aphase.valid && aphase.write) begin
            case (aphase.idx)
                `ASRAD_IDX_RXCTL: next_rx_ctl    = wbyte & `ASRAD_RXCTL_WMASK;
                `ASRAD_IDX_IE:    next_irq_en    = wbyte;
                `ASRAD_IDX_TXCTL: next_tx_ctl    = wbyte & `ASRAD_TXCTL_WMASK;
                `ASRAD_IDX_BAUD:  next_baud_div  = wbyte;
                default:          next_baud_div  = baud_div;
            endcase
        end
        next_irq = flag & irq_en[`ASRAD_B_IE];                               // RL4
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_ctl        <= `ASRAD_RST_REG;
            tx_ctl        <= `ASRAD_RST_REG;
            irq_en        <= `ASRAD_RST_REG;
            baud_div      <= `ASRAD_RST_REG;
            overrun_error <= 1'b0;
            fifo_mem[0] <= '0;
            fifo_mem[1] <= '0;
            head        <= 1'b0;
            count       <= 2'h0;
            state       <= ASRAD_IDLE;
            tick_cnt    <= 4'h0;
            bit_cnt     <= 4'h0;
            shift       <= 9'h000;
            nine        <= 1'b0;
            baud_cnt    <= 8'h00;
            pre_cnt     <= 2'h0;
            aphase      <= '0;
            hrdata      <= 32'h00000000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            rx_irq      <= 1'b0;
        end else begin
            rx_ctl        <= next_rx_ctl;
            tx_ctl        <= next_tx_ctl;
            irq_en        <= next_irq_en;
            baud_div      <= next_baud_div;
            overrun_error <= next_overrun_error;
            fifo_mem[0] <= next_mem[0];
            fifo_mem[1] <= next_mem[1];
            head        <= next_head;
            count       <= next_count;
            state       <= next_state;
            tick_cnt    <= next_tick_cnt;
            bit_cnt     <= next_bit_cnt;
            shift       <= next_shift;
            nine        <= next_nine;
            baud_cnt    <= next_baud_cnt;
            pre_cnt     <= next_pre_cnt;
            aphase      <= next_aphase;
            hrdata      <= next_hrdata;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            rx_irq      <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_overrun_stop;
        finish && full;
    endsequence
    sequence s_last_pop;
        pop && !push && count == 2'h1;
    endsequence

    // A read in the same cycle as the stop sample still leaves the word lost
    property p_overrun_set;
        s_overrun_stop |=> overrun_error && count == 2'h2 - {1'b0, $past(pop)};
    endproperty
    a_overrun_set: assert property (p_overrun_set)                           // RL7
        else $error("overrun not flagged on full FIFO");
    property p_overrun_sticky;
        overrun_error && rx_ctl[`ASRAD_B_RX_EN] |=> overrun_error;
    endproperty
    a_overrun_sticky: assert property (p_overrun_sticky)                     // RL8
        else $error("overrun cleared without receive_enable toggle");
    property p_overrun_blocks;
        overrun_error && !pop |=> count == $past(count);
    endproperty
    a_overrun_blocks: assert property (p_overrun_blocks)                     // RL9
        else $error("word entered FIFO during overrun");
    property p_flag_clears;
        s_last_pop |=> !flag ##1 !rx_irq;
    endproperty
    a_flag_clears: assert property (p_flag_clears)                           // RL5
        else $error("ready flag stayed set with empty FIFO");
    property p_push_flag;
        push |=> flag [*1] ##1 (flag || $past(pop));
    endproperty
    a_push_flag: assert property (p_push_flag)                               // RL3
        else $error("ready flag not set after transfer");
    property p_irq_gate;
        rx_irq |-> $past(irq_en[`ASRAD_B_IE]) && $past(flag);
    endproperty
    a_irq_gate: assert property (p_irq_gate)                                 // RL4
        else $error("interrupt forwarded while disabled");
    property p_depth;
        count != 2'h3 && !(full && push);
    endproperty
    a_depth: assert property (p_depth)                                       // RL6
        else $error("FIFO depth exceeded");
    property p_pop_order;
        pop |=> head != $past(head);
    endproperty
    a_pop_order: assert property (p_pop_order)                               // RL6 RL11
        else $error("read did not advance to next entry");
    property p_disabled_idle;
        !rx_on |=> state == ASRAD_IDLE && !finish;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle)                       // RL2 RL19
        else $error("receiver active while disabled");
    property p_addr_filter;
        finish && rx_ctl[`ASRAD_B_ADDR_EN] && nine && !shift[8] |-> !push;
    endproperty
    a_addr_filter: assert property (p_addr_filter)                           // RL15 RL17
        else $error("data word loaded while filtering");
    property p_eight_bit;
        push && !nine |-> !push_entry.ninth;
    endproperty
    a_eight_bit: assert property (p_eight_bit)                               // RL13
        else $error("ninth bit reported in eight-bit mode");
    // Divisor zero at x16 must give a tick on every clock
    property p_tick_rate;
        sample_tick && tx_ctl[`ASRAD_B_HIGH_SPEED] && baud_div == 8'h00
            |=> sample_tick || !tx_ctl[`ASRAD_B_HIGH_SPEED];
    endproperty
    a_tick_rate: assert property (p_tick_rate)                               // RL1 RL20
        else $error("sample tick spacing wrong");

endmodule : asrad_receiver

// File: verification/asrad_serial_tx.sv
// Behavioural model of the remote asynchronous transmitter on the receive line
`timescale 1ns/1ps

module asrad_serial_tx (
    input  wire logic hclk,
    output logic      line
);
    // Mark level between frames, as a released sender leaves the line
    initial begin
        line = 1'b1;
    end

    // Caller must be just past a rising edge so the level changes off the sampling edge
    task automatic hold_bit(input logic level, input int clks);
        line <= level;
        repeat (clks) @(posedge hclk);
    endtask : hold_bit

    // Start bit, data LSB first, one stop bit; a bad stop is followed by one idle bit
    task automatic send(input logic [8:0] word, input int nbits, input int clks,
                        input logic stop_level);
        hold_bit(1'b0, clks);
        for (int i = 0; i < nbits; i++) begin
            hold_bit(word[i], clks);
        end
        hold_bit(stop_level, clks);
        if (stop_level !== 1'b1) begin
            hold_bit(1'b1, clks);
        end
    endtask : send

endmodule : asrad_serial_tx

// File: verification/asrad_receiver_tb.sv
// Self-checking testbench of the serial receiver, its register bus and the line model
`timescale 1ns/1ps

module asrad_receiver_tb;
    import asrad_pkg::*;

    localparam int          TIMEOUT_CYCLES = 20000;
    localparam int          FAST_BIT       = 16;
    localparam int          SLOW_BIT       = 64;
    localparam logic [31:0] ALL            = 32'hffff_ffff;
    localparam logic [31:0] A_FLAG         = 32'h0000_0030;
    localparam logic [31:0] A_RXCTL        = 32'h0000_0060;
    localparam logic [31:0] A_FIFO         = 32'h0000_0068;
    localparam logic [31:0] A_IE           = 32'h0000_0230;
    localparam logic [31:0] A_TXCTL        = 32'h0000_0260;
    localparam logic [31:0] A_BAUD         = 32'h0000_0264;
    localparam logic [31:0] MAP_ADDR [0:6] = '{A_FLAG, A_RXCTL, A_FIFO, A_IE, A_TXCTL, A_BAUD,
                                               32'h0000_0100};
    localparam logic [31:0] MAP_RST  [0:6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0};

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        rx_line;
    logic        rx_irq;
    logic [31:0] rd;
    int          err_count = 0;
    int          checks_done = 0;
    int          cycles = 0;

    asrad_receiver u_asrad_receiver (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rx_pin    (rx_line),
        .rx_irq    (rx_irq)
    );

    asrad_serial_tx u_asrad_serial_tx (
        .hclk (hclk),
        .line (rx_line)
    );

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic end_of_test();
        $display("Checks done %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // A lost handshake ends the run here rather than hanging
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles >= TIMEOUT_CYCLES) begin
            err_count++;
            $display("Error timeout after %0d cycles", cycles);
            end_of_test();
        end
    end

    // ----------------------------------------
    // Bus and line access
    // ----------------------------------------
    task automatic wait_ready();
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : wait_ready

    task automatic ahb_write(input logic [31:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= 1'b1;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_ready();
    endtask : ahb_write

    task automatic read_chk(input string name, input logic [31:0] a, input logic [31:0] exp,
                            input logic [31:0] mask);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= 1'b0;
        wait_ready();
        htrans <= 2'b00;
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
        chk(name, exp, rd & mask);
    endtask : read_chk

    // Room after the stop bit for the push, the flag and the interrupt to land
    task automatic frame(input logic [8:0] w, input int nbits, input int clks, input logic stop);
        u_asrad_serial_tx.send(w, nbits, clks, stop);
        repeat (4) @(posedge hclk);
    endtask : frame

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'b00;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            read_chk("reset value", MAP_ADDR[i], MAP_RST[i], ALL);
        end
        ahb_write(A_IE, 8'hff);
        read_chk("irq enable", A_IE, 32'hff, ALL);
        ahb_write(A_TXCTL, 8'hff);
        read_chk("tx control", A_TXCTL, 32'hf7, ALL);
        ahb_write(A_FLAG, 8'hff);
        read_chk("flag ro", A_FLAG, 32'h0, ALL);
        // One clock per tick keeps a bit at 16 cycles
        ahb_write(A_BAUD, 8'h00);
        ahb_write(A_TXCTL, 8'h04);
        ahb_write(A_RXCTL, 8'h80);
        frame(9'h03c, 8, FAST_BIT, 1'b1);
        read_chk("flag disabled", A_FLAG, 32'h0, ALL);
        ahb_write(A_RXCTL, 8'h90);
        ahb_write(A_TXCTL, 8'h14);
        frame(9'h03c, 8, FAST_BIT, 1'b1);
        read_chk("flag sync", A_FLAG, 32'h0, ALL);
        ahb_write(A_TXCTL, 8'h04);
        frame(9'h0a5, 8, FAST_BIT, 1'b1);
        read_chk("ready flag", A_FLAG, 32'h20, ALL);
        chk("irq on", 32'h1, {31'h0, rx_irq});
        ahb_write(A_IE, 8'h00);
        repeat (2) @(posedge hclk);
        chk("irq masked", 32'h0, {31'h0, rx_irq});
        read_chk("status 8 bit", A_RXCTL, 32'h90, ALL);
        read_chk("data 8 bit", A_FIFO, 32'ha5, ALL);
        read_chk("flag drained", A_FLAG, 32'h0, ALL);
        frame(9'h011, 8, FAST_BIT, 1'b1);
        frame(9'h022, 8, FAST_BIT, 1'b0);
        frame(9'h033, 8, FAST_BIT, 1'b1);
        read_chk("status overrun", A_RXCTL, 32'h92, ALL);
        read_chk("first word", A_FIFO, 32'h11, ALL);
        read_chk("status framing", A_RXCTL, 32'h96, ALL);
        read_chk("second word", A_FIFO, 32'h22, ALL);
        frame(9'h044, 8, FAST_BIT, 1'b1);
        read_chk("flag locked", A_FLAG, 32'h0, ALL);
        ahb_write(A_RXCTL, 8'h90);
        read_chk("overrun kept", A_RXCTL, 32'h92, 32'hfa);
        ahb_write(A_RXCTL, 8'h80);
        ahb_write(A_RXCTL, 8'h90);
        read_chk("overrun clear", A_RXCTL, 32'h90, 32'hfa);
        frame(9'h05a, 8, FAST_BIT, 1'b1);
        read_chk("word resumed", A_FIFO, 32'h5a, ALL);
        ahb_write(A_RXCTL, 8'hc8);
        ahb_write(A_RXCTL, 8'hd8);
        frame(9'h055, 9, FAST_BIT, 1'b1);
        frame(9'h1aa, 9, FAST_BIT, 1'b1);
        read_chk("addr status", A_RXCTL, 32'hd9, ALL);
        read_chk("addr word", A_FIFO, 32'haa, ALL);
        read_chk("data dropped", A_FLAG, 32'h0, ALL);
        ahb_write(A_RXCTL, 8'hd0);
        frame(9'h0c3, 9, FAST_BIT, 1'b1);
        read_chk("data status", A_RXCTL, 32'hd0, ALL);
        read_chk("data word", A_FIFO, 32'hc3, ALL);
        ahb_write(A_RXCTL, 8'h90);
        ahb_write(A_TXCTL, 8'h00);
        frame(9'h096, 8, SLOW_BIT, 1'b1);
        read_chk("slow word", A_FIFO, 32'h96, ALL);
        end_of_test();
    end

endmodule : asrad_receiver_tb
